// file: logic/sar_adc_conversion_control.sv
// Operation
// - ten-bit result by successive approximation, eight inputs
// - eight-bit mode gives shorter conversion, high byte
// - ten-bit conversion lasts fifty cycles
// - eight-bit conversion lasts twenty-four cycles
// - keep-active bit decides power during idle
// - external enable low: software start only
// - external enable high: software or pin edge
// - pin edge seen at cycle end, start next
// - software start begins on following cycle
// - start is command flop plus status flag
// - two init cycles, status set after first
// - eight cycles (six in eight-bit mode) sample selected channel
// - trial bits from MSB, keep if input higher
// - four cycles per bit trial, two in eight-bit mode
// - done flag, high byte, two low bits
// - done set, status cleared after full count
// - low three control bits pick channel
// - starts during conversion are ignored
// - idle without keep-active bit, or power-down, aborts, result kept
// - hardware never clears done flag
// - software clears done, writing one ignored
`timescale 1ns/1ps
module sar_adc_conversion_control (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [sar_adc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // power modes
  input wire logic idle_mode,
  input wire logic power_down,
  // analog front end
  input wire logic start_trigger_pin,
  input wire logic comp_gt,
  output logic [sar_adc_pkg::CHAN_W-1:0] chan_sel,
  output logic [sar_adc_pkg::RES_W-1:0] dac_code,
  output logic sample_en,
  output logic adc_power_on,
  // status
  output logic conversion_done,
  output logic converting
);

  sar_adc_pkg::state_s s_r;
  sar_adc_pkg::state_s s_nxt;
  logic off;
  logic rise;
  logic fin;
  logic wr_ctrl;
  logic [3:0] samp_len;
  logic [3:0] trial_len;
  logic [3:0] last_idx;
  logic [7:0] high_byte;
  logic [7:0] elapsed_r;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    fin = 1'b0;
    off = power_down | (idle_mode & ~s_r.keep);
    rise = start_trigger_pin & ~s_r.pin_prev;
    wr_ctrl = wr_en && (addr == sar_adc_pkg::OFF_CTRL);
    samp_len = s_r.eight ? sar_adc_pkg::SAMP8 : sar_adc_pkg::SAMP10;
    trial_len = s_r.eight ? sar_adc_pkg::TRIAL8 : sar_adc_pkg::TRIAL10;
    last_idx = s_r.eight ? sar_adc_pkg::LAST8 : sar_adc_pkg::LAST10;
    s_nxt.pin_prev = start_trigger_pin;
    s_nxt.power_on = ~off;
    s_nxt.rdata = 8'h00;

    // register writes
    if (wr_ctrl) begin
      s_nxt.ext_en = wr_data[sar_adc_pkg::B_EXT];
      s_nxt.chan = wr_data[sar_adc_pkg::CHAN_W-1:0];
      if (!wr_data[sar_adc_pkg::B_DONE]) begin
        s_nxt.done = 1'b0;
      end
    end
    if (wr_en && (addr == sar_adc_pkg::OFF_AUX)) begin
      s_nxt.eight = wr_data[sar_adc_pkg::B_EIGHT];
      s_nxt.keep = wr_data[sar_adc_pkg::B_KEEP];
    end

    // start requests set the command flop only while idle
    if ((s_r.phase == sar_adc_pkg::ST_IDLE) && !s_r.cmd && !off) begin
      if (wr_ctrl && wr_data[sar_adc_pkg::B_START]) begin
        s_nxt.cmd = 1'b1;
      end
      if (s_r.ext_en && rise) begin
        s_nxt.cmd = 1'b1;
      end
    end

    // sequencer
    case (s_r.phase)
      sar_adc_pkg::ST_IDLE: begin
        if (s_r.cmd) begin
          s_nxt.cmd = 1'b0;
          s_nxt.status = 1'b1;
          s_nxt.phase = sar_adc_pkg::ST_INIT;
        end
      end
      sar_adc_pkg::ST_INIT: begin
        s_nxt.phase = sar_adc_pkg::ST_SAMPLE;
        s_nxt.sample_en = 1'b1;
        s_nxt.cnt = 4'h0;
      end
      sar_adc_pkg::ST_SAMPLE: begin
        if (s_r.cnt == samp_len - 4'h1) begin
          s_nxt.sample_en = 1'b0;
          s_nxt.phase = sar_adc_pkg::ST_TRIAL;
          s_nxt.sar = sar_adc_pkg::SAR_MSB;
          s_nxt.bit_idx = sar_adc_pkg::MSB_IDX;
          s_nxt.cnt = 4'h0;
        end else begin
          s_nxt.cnt = s_r.cnt + 4'h1;
        end
      end
      sar_adc_pkg::ST_TRIAL: begin
        if (s_r.cnt == trial_len - 4'h2) begin
          s_nxt.comp = comp_gt;
        end
        if (s_r.cnt == trial_len - 4'h1) begin
          s_nxt.cnt = 4'h0;
          if (!s_r.comp) begin
            s_nxt.sar[s_r.bit_idx] = 1'b0;
          end
          if (s_r.bit_idx == last_idx) begin
            fin = 1'b1;
            s_nxt.res = s_nxt.sar;
            s_nxt.done = 1'b1;
            s_nxt.status = 1'b0;
            s_nxt.phase = sar_adc_pkg::ST_IDLE;
          end else begin
            s_nxt.bit_idx = s_r.bit_idx - 4'h1;
            s_nxt.sar[s_r.bit_idx - 4'h1] = 1'b1;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 4'h1;
        end
      end
      default: begin
        s_nxt.phase = sar_adc_pkg::ST_IDLE;
      end
    endcase

    // power loss aborts; finished result and done flag stay
    if (off) begin
      fin = 1'b0;
      s_nxt.phase = sar_adc_pkg::ST_IDLE;
      s_nxt.cmd = 1'b0;
      s_nxt.status = 1'b0;
      s_nxt.sample_en = 1'b0;
      s_nxt.res = s_r.res;
      s_nxt.done = s_r.done & ~(wr_ctrl & ~wr_data[sar_adc_pkg::B_DONE]);
    end

    // register reads
    if (rd_en) begin
      case (addr)
        sar_adc_pkg::OFF_CTRL: begin
          s_nxt.rdata = {s_r.res[1], s_r.res[0], s_r.ext_en, s_r.done, s_r.status,
                         s_r.chan};
        end
        sar_adc_pkg::OFF_HIGH: begin
          s_nxt.rdata = s_r.res[sar_adc_pkg::RES_W-1:sar_adc_pkg::HIGH_LSB];
        end
        sar_adc_pkg::OFF_AUX: begin
          s_nxt.rdata = {s_r.eight, s_r.keep, 6'h00};
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= sar_adc_pkg::STATE_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rdata;
  assign chan_sel = s_r.chan;
  assign dac_code = s_r.sar;
  assign sample_en = s_r.sample_en;
  assign adc_power_on = s_r.power_on;
  assign conversion_done = s_r.done;
  assign converting = s_r.status;
  assign high_byte = s_r.res[sar_adc_pkg::RES_W-1:sar_adc_pkg::HIGH_LSB];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // cycles spent with the status flag up, for the length check
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elapsed_r <= 8'h00;
    end else if (ce) begin
      if (!s_r.status) begin
        elapsed_r <= 8'h00;
      end else begin
        elapsed_r <= elapsed_r + 8'h01;
      end
    end
  end

  AST_START_INIT: assert property (@(posedge clk) disable iff (rst)
    ce && !off && s_r.cmd && (s_r.phase == sar_adc_pkg::ST_IDLE)
    |=> (s_r.phase == sar_adc_pkg::ST_INIT) && s_r.status && !s_r.cmd)
    else $error("start did not enter init");

  AST_INIT_SAMPLE: assert property (@(posedge clk) disable iff (rst)
    ce && !off && (s_r.phase == sar_adc_pkg::ST_INIT)
    |=> (s_r.phase == sar_adc_pkg::ST_SAMPLE) && sample_en)
    else $error("init did not lead to sampling");

  AST_LENGTH: assert property (@(posedge clk) disable iff (rst)
    ce && fin |-> elapsed_r == (s_r.eight ? 8'(sar_adc_pkg::CONV8_CYC - 2)
                                          : 8'(sar_adc_pkg::CONV10_CYC - 2)))
    else $error("conversion length wrong");

  AST_DONE_KEPT: assert property (@(posedge clk) disable iff (rst)
    s_r.done && !(ce && wr_ctrl && !wr_data[sar_adc_pkg::B_DONE]) |=> s_r.done)
    else $error("done flag cleared by hardware");

  AST_DONE_NO_SW_SET: assert property (@(posedge clk) disable iff (rst)
    ce && !s_r.done && !fin && wr_ctrl && wr_data[sar_adc_pkg::B_DONE] |=> !s_r.done)
    else $error("software set the done flag");

  AST_BUSY_IGNORE: assert property (@(posedge clk) disable iff (rst)
    ce && (s_r.phase != sar_adc_pkg::ST_IDLE) |=> !s_r.cmd)
    else $error("start accepted while busy");

  AST_EXT_EDGE: assert property (@(posedge clk) disable iff (rst)
    ce && !off && s_r.ext_en && rise && !s_r.cmd && (s_r.phase == sar_adc_pkg::ST_IDLE)
    |=> s_r.cmd ##1 (!ce || converting))
    else $error("pin edge not taken");

  AST_SW_ONLY: assert property (@(posedge clk) disable iff (rst)
    ce && !s_r.ext_en && !s_r.cmd && !(wr_ctrl && wr_data[sar_adc_pkg::B_START])
    |=> !s_r.cmd)
    else $error("start without software request");

  AST_ABORT: assert property (@(posedge clk) disable iff (rst)
    ce && off |=> (s_r.phase == sar_adc_pkg::ST_IDLE) && !converting && !adc_power_on)
    else $error("power loss did not abort");

  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (rst)
    ce && !off && (s_r.phase == sar_adc_pkg::ST_SAMPLE) && (s_r.cnt == samp_len - 4'h1)
    |=> dac_code == sar_adc_pkg::SAR_MSB)
    else $error("approximation not started at msb");

  AST_READ_HIGH: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && (addr == sar_adc_pkg::OFF_HIGH) |=> rd_data == $past(high_byte))
    else $error("high byte read wrong");

  // ---------------------------------------------------------------
  // register port and sequencer detail checks
  // ---------------------------------------------------------------
  AST_READ_STATUS: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && (addr == sar_adc_pkg::OFF_CTRL)
    |=> rd_data[sar_adc_pkg::B_START] == $past(s_r.status))
    else $error("status bit read wrong");

  AST_READ_CHAN: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && (addr == sar_adc_pkg::OFF_CTRL)
    |=> rd_data[sar_adc_pkg::CHAN_W-1:0] == $past(chan_sel))
    else $error("channel field read wrong");

  AST_READ_LOW: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && (addr == sar_adc_pkg::OFF_CTRL)
    |=> rd_data[sar_adc_pkg::B_RES1:sar_adc_pkg::B_RES0] == $past(s_r.res[1:0]))
    else $error("low result bits read wrong");

  AST_READ_IDLE: assert property (@(posedge clk) disable iff (rst)
    ce && !rd_en
    |=> rd_data == 8'h00)
    else $error("read data stood too long");

  AST_CHAN_WRITE: assert property (@(posedge clk) disable iff (rst)
    ce && wr_ctrl
    |=> chan_sel == $past(wr_data[sar_adc_pkg::CHAN_W-1:0]))
    else $error("channel write lost");

  AST_EXT_WRITE: assert property (@(posedge clk) disable iff (rst)
    ce && wr_ctrl
    |=> s_r.ext_en == $past(wr_data[sar_adc_pkg::B_EXT]))
    else $error("external enable write lost");

  AST_AUX_WRITE: assert property (@(posedge clk) disable iff (rst)
    ce && wr_en && (addr == sar_adc_pkg::OFF_AUX)
    |=> s_r.eight == $past(wr_data[sar_adc_pkg::B_EIGHT]))
    else $error("auxiliary write lost");

  AST_SAMPLE_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && !off && (s_r.phase == sar_adc_pkg::ST_SAMPLE) && (s_r.cnt < samp_len - 4'h1)
    |=> sample_en)
    else $error("sampling ended early");

  AST_SAMPLE_OFF: assert property (@(posedge clk) disable iff (rst)
    ce && (s_r.phase == sar_adc_pkg::ST_TRIAL)
    |=> !sample_en)
    else $error("sampling during trials");

  AST_COMP_LATCH: assert property (@(posedge clk) disable iff (rst)
    ce && (s_r.phase == sar_adc_pkg::ST_TRIAL) && (s_r.cnt == trial_len - 4'h2)
    |=> s_r.comp == $past(comp_gt))
    else $error("comparator not registered");

  AST_TRIAL_DROP: assert property (@(posedge clk) disable iff (rst)
    ce && !off && (s_r.phase == sar_adc_pkg::ST_TRIAL) && (s_r.cnt == trial_len - 4'h1) && !s_r.comp
    |=> dac_code < $past(dac_code))
    else $error("rejected bit not cleared");

  AST_TRIAL_KEEP: assert property (@(posedge clk) disable iff (rst)
    ce && !off && (s_r.phase == sar_adc_pkg::ST_TRIAL) && (s_r.cnt == trial_len - 4'h1)
    && s_r.comp && (s_r.bit_idx != last_idx) |=> dac_code > $past(dac_code))
    else $error("kept bit lost or next bit not set");

  AST_DONE_RESULT: assert property (@(posedge clk) disable iff (rst)
    ce && fin
    |=> conversion_done && !converting)
    else $error("end of conversion not flagged");

  AST_NO_EARLY_DONE: assert property (@(posedge clk) disable iff (rst)
    ce && !fin && !s_r.done
    |=> !conversion_done)
    else $error("done flag set without a finished conversion");

  AST_STATUS_PHASE: assert property (@(posedge clk) disable iff (rst)
    converting == (s_r.phase != sar_adc_pkg::ST_IDLE))
    else $error("status flag does not track conversion");

  AST_POWER_ON: assert property (@(posedge clk) disable iff (rst)
    ce && !off
    |=> adc_power_on)
    else $error("converter off while allowed to run");

  AST_KEEP_IDLE: assert property (@(posedge clk) disable iff (rst)
    ce && idle_mode && s_r.keep && !power_down && converting && !fin
    |=> converting)
    else $error("conversion stopped in idle with keep set");

  AST_EIGHT_LOW: assert property (@(posedge clk) disable iff (rst)
    ce && fin && s_r.eight
    |=> dac_code[1:0] == 2'b00)
    else $error("eight-bit mode tested low bits");

  AST_OFF_NO_CMD: assert property (@(posedge clk) disable iff (rst)
    ce && off
    |=> !s_r.cmd)
    else $error("start kept while off");

  AST_RES_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && !fin
    |=> $stable(s_r.res))
    else $error("result changed without a finished conversion");

endmodule : sar_adc_conversion_control

// file: logic/sar_adc_pkg.sv
package sar_adc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] OFF_HIGH = 2'h1;
  localparam logic [ADDR_W-1:0] OFF_AUX = 2'h2;

  // converter_control fields
  localparam int B_RES1 = 7;
  localparam int B_RES0 = 6;
  localparam int B_EXT = 5;
  localparam int B_DONE = 4;
  localparam int B_START = 3;
  localparam int CHAN_W = 3;

  // auxiliary_control fields
  localparam int B_EIGHT = 7;
  localparam int B_KEEP = 6;

  // ---------------------------------------------------------------
  // conversion timing, in machine cycles
  // ---------------------------------------------------------------
  localparam int RES_W = 10;
  localparam int HIGH_LSB = 2;
  localparam int CONV10_CYC = 50;
  localparam int CONV8_CYC = 24;
  localparam logic [3:0] SAMP10 = 4'h8;
  localparam logic [3:0] SAMP8 = 4'h6;
  localparam logic [3:0] TRIAL10 = 4'h4;
  localparam logic [3:0] TRIAL8 = 4'h2;
  localparam logic [3:0] LAST10 = 4'h0;
  localparam logic [3:0] LAST8 = 4'h2;
  localparam logic [3:0] MSB_IDX = 4'h9;
  localparam logic [RES_W-1:0] SAR_MSB = 10'h200;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INIT,
    ST_SAMPLE,
    ST_TRIAL
  } phase_e;

  typedef struct packed {
    phase_e phase;
    logic cmd;
    logic status;
    logic done;
    logic ext_en;
    logic [CHAN_W-1:0] chan;
    logic eight;
    logic keep;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] res;
    logic [3:0] bit_idx;
    logic [3:0] cnt;
    logic comp;
    logic pin_prev;
    logic [7:0] rdata;
    logic power_on;
    logic sample_en;
  } state_s;

  localparam state_s STATE_RST = '0;

endpackage : sar_adc_pkg

// file: sim/sar_front_end_model.sv
`timescale 1ns/1ps
module sar_front_end_model (
  // clock
  input wire logic clk,
  // converter side
  input wire logic [2:0] chan_sel,
  input wire logic [9:0] dac_code,
  input wire logic sample_en,
  input wire logic adc_power_on,
  output logic comp_gt,
  output logic start_trigger_pin
);
  // ----
  // analog inputs and comparator
  // ----
  logic [9:0] vin [8];
  logic [9:0] held;
  logic junk;
  initial begin
    vin = '{10'h000, 10'h155, 10'h2AA, 10'h0FF, 10'h301, 10'h1C7, 10'h200, 10'h3FF};
    held = 10'h000;
    junk = 1'b0;
    start_trigger_pin = 1'b1;
  end
  // hold capacitor follows the selected input only while sampling
  always @(posedge clk) begin
    junk <= ~junk;
    if (sample_en) held <= vin[chan_sel];
  end
  // an unpowered comparator gives no usable decision
  assign comp_gt = adc_power_on ? (held > dac_code) : junk;
  task ext_pulse;
    @(posedge clk) start_trigger_pin <= 1'b0;
    @(posedge clk) start_trigger_pin <= 1'b1;
    @(posedge clk);
  endtask : ext_pulse
endmodule : sar_front_end_model

// file: sim/tb_sar_adc_conversion_control.sv
`timescale 1ns/1ps
module tb_sar_adc_conversion_control;
  // ----
  // design and partner
  // ----
  logic clk, rst, ce, wr_en, rd_en, idle_mode, power_down, pin, comp_gt;
  logic [1:0] addr;
  logic [7:0] wr_data, rd_data, rv;
  logic [2:0] chan_sel;
  logic [9:0] dac_code, exp_r;
  logic sample_en, power_on, done, busy;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int t0;
  sar_adc_conversion_control u_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .idle_mode(idle_mode), .power_down(power_down), .start_trigger_pin(pin),
    .comp_gt(comp_gt), .chan_sel(chan_sel), .dac_code(dac_code), .sample_en(sample_en),
    .adc_power_on(power_on), .conversion_done(done), .converting(busy));
  sar_front_end_model u_afe (.clk(clk), .chan_sel(chan_sel), .dac_code(dac_code),
    .sample_en(sample_en), .adc_power_on(power_on), .comp_gt(comp_gt),
    .start_trigger_pin(pin));
  // ----
  // tasks
  // ----
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask : rd
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  function automatic logic [9:0] sar_ref(input logic [9:0] v, input int nb);
    logic [9:0] r;
    r = 10'h000;
    for (int i = 9; i >= 10 - nb; i--) begin
      if (v > (r | (10'h001 << i))) r = r | (10'h001 << i);
    end
    return r;
  endfunction : sar_ref
  task run(input logic [2:0] ch, input logic ext, input int nb, input int cyc);
    exp_r = sar_ref(u_afe.vin[ch], nb);
    wr(2'h0, {2'b00, ext, 1'b0, !ext, ch});
    if (ext) u_afe.ext_pulse();
    #1 t0 = cycles;
    wr(2'h0, {2'b00, ext, 2'b01, ch});
    rd(2'h0);
    chk(rv[4:3], 2'b01, "status while busy");
    chk(sample_en, 1'b1, "sampling");
    while (done !== 1'b1 && cycles - t0 < 200) tick(1);
    chk(10'(cycles - t0), 10'(cyc), "conversion length");
    chk(busy, 1'b0, "status cleared");
    chk(chan_sel, ch, "channel select");
    rd(2'h1);
    chk(rv, exp_r[9:2], "high byte");
    rd(2'h0);
    chk(rv[7:6], exp_r[1:0], "low bits");
    wr(2'h0, {2'b00, ext, 2'b10, ch});
    tick(10);
    chk(done, 1'b1, "done kept");
    wr(2'h0, {2'b00, ext, 2'b00, ch});
    tick(1);
    chk(done, 1'b0, "done cleared");
    $display("test conversion ch %0d bits %0d done", ch, nb);
  endtask : run
  // ----
  // clock, timeout, sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    idle_mode = 1'b0;
    power_down = 1'b0;
    addr = 2'h0;
    wr_data = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(2'(a));
      chk(rv, 8'h00, "reset value");
    end
    $display("test reset done");
    for (int c = 0; c < 8; c++) run(3'(c), 1'b0, 10, 50);
    wr(2'h2, 8'h80);
    run(3'h3, 1'b0, 8, 24);
    wr(2'h2, 8'h40);
    @(posedge clk) idle_mode <= 1'b1;
    run(3'h6, 1'b1, 10, 50);
    wr(2'h2, 8'h00);
    tick(2);
    chk(power_on, 1'b0, "idle power off");
    @(posedge clk) idle_mode <= 1'b0;
    wr(2'h0, 8'h01);
    u_afe.ext_pulse();
    tick(3);
    chk(busy, 1'b0, "pin ignored");
    for (int m = 0; m < 2; m++) begin
      wr(2'h0, 8'h09);
      tick(20);
      @(posedge clk) {power_down, idle_mode} <= m[0] ? 2'b10 : 2'b01;
      tick(3);
      chk({power_on, busy, done}, 3'b000, "abort");
      @(posedge clk) {power_down, idle_mode} <= 2'b00;
      tick(3);
    end
    wr(2'h0, 8'h0A);
    tick(60);
    @(posedge clk) idle_mode <= 1'b1;
    tick(3);
    rd(2'h1);
    exp_r = sar_ref(u_afe.vin[2], 10);
    chk({done, rv}, {1'b1, exp_r[9:2]}, "result kept in idle");
    $display("test modes done");
    close_out();
  end
endmodule : tb_sar_adc_conversion_control
